// >>> core/fbg_guard.sv
// Flash block write guard top: APB registers and access screening.
// Assumes an APB master on clk_sys_i and a flash controller that holds
// a request until it sees grant or deny.
////////////////////////////////////////////////////////////////////////////////
module fbg_guard
  import fbg_pkg::*;
// Behaviour
// - Low guard register at 0x600, resets zero
// - High guard register at 0x604, sixteen bits
// - Bit set means region protected
// - Writing one sets, zero leaves bit
// - Debug override at 0x608, resets to one
// - Override acts only in debug mode
// - Each bit covers one 4 kB block
// - Protected block write refused, hard fault
// - Chip erase refused when any protected
// - Only reset clears guard bits
(
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire fbg_pkg::fbg_apb_req_t apb_i,
  output fbg_pkg::fbg_apb_rsp_t      apb_o,
  input  wire logic         debug_mode_i,
  input  wire fbg_pkg::fbg_nvm_req_t nvm_req_i,
  output fbg_pkg::fbg_nvm_rsp_t      nvm_rsp_o,
  output logic              irq_o
);
  import fbg_pkg::*;

  typedef struct packed {
    logic [31:0]          guard_low;
    logic [15:0]          guard_high;
    logic                 dbg_ovr;
    logic [1:0]           irq_mask;
    logic [1:0]           irq_clear;
    logic [1:0]           events;
    logic [2:0]           dbg_sync;
    logic                 dbg_mode;
    fbg_apb_rsp_t         apb;
    fbg_nvm_rsp_t         nvm;
  } fbg_state_t;

  fbg_state_t st;
  fbg_state_t next_st;

  logic [FBG_REGIONS-1:0] guard;
  logic                   hit_block;
  logic                   hit_chip;
  logic [1:0]             irq_status;
  logic                   irq_line;
  logic                   enforce;
  logic                   refuse;
  logic                   wr_access;
  logic                   rd_access;

  ////////////////////////////////////////////////////////////////////////////
  // Access screening
  assign guard = {st.guard_high, st.guard_low};

  fbg_region_check u_check (
    .guard_i     (guard),
    .addr_i      (nvm_req_i.addr),
    .erase_all_i (nvm_req_i.is_erase_all),
    .hit_block_o (hit_block),
    .hit_chip_o  (hit_chip)
  );

  fbg_irq #(
    .N (2)
  ) u_irq (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .event_i   (st.events),
    .clear_i   (st.irq_clear),
    .mask_i    (st.irq_mask),
    .status_o  (irq_status),
    .irq_o     (irq_line)
  );

  always_comb begin
    enforce   = !(st.dbg_mode && st.dbg_ovr);
    refuse    = enforce && (hit_block || hit_chip);
    wr_access = apb_i.psel && apb_i.penable && apb_i.pwrite;
    rd_access = apb_i.psel && !apb_i.penable && !apb_i.pwrite;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st           = st;
    next_st.irq_clear = 2'h0;
    next_st.events    = 2'h0;
    next_st.dbg_sync  = {st.dbg_sync[1:0], debug_mode_i};
    if (st.dbg_sync[2] == st.dbg_sync[1]) begin
      next_st.dbg_mode = st.dbg_sync[2];
    end

    // Screening answer, one cycle after a valid request
    next_st.nvm = '0;
    if (nvm_req_i.valid && !st.nvm.grant && !st.nvm.deny) begin
      next_st.nvm.grant = !refuse;
      next_st.nvm.deny  = refuse;
      next_st.nvm.fault = refuse;
      next_st.events[FBG_IRQ_BLOCK_BIT] = enforce && hit_block;
      next_st.events[FBG_IRQ_CHIP_BIT]  = enforce && hit_chip;
    end

    // APB: ready in access phase, no wait states
    next_st.apb.pready  = apb_i.psel && !apb_i.penable;
    next_st.apb.pslverr = 1'b0;
    if (rd_access) begin
      case (apb_i.paddr)
        FBG_OFF_GUARD_LOW:  next_st.apb.prdata = st.guard_low;
        FBG_OFF_GUARD_HIGH: next_st.apb.prdata = {16'h0000, st.guard_high};
        FBG_OFF_DBG_OVR:    next_st.apb.prdata = {31'h0, st.dbg_ovr};
        FBG_OFF_SPARE:      next_st.apb.prdata = 32'h0000_0000;
        FBG_OFF_IRQ_STAT:   next_st.apb.prdata = {30'h0, irq_status};
        FBG_OFF_IRQ_MASK:   next_st.apb.prdata = {30'h0, st.irq_mask};
        default: begin
          next_st.apb.prdata  = 32'h0000_0000;
          next_st.apb.pslverr = 1'b1;
        end
      endcase
    end else if (apb_i.psel && !apb_i.penable) begin
      next_st.apb.prdata = 32'h0000_0000;
      case (apb_i.paddr)
        FBG_OFF_GUARD_LOW, FBG_OFF_GUARD_HIGH, FBG_OFF_DBG_OVR,
        FBG_OFF_SPARE, FBG_OFF_IRQ_STAT, FBG_OFF_IRQ_MASK: next_st.apb.pslverr = 1'b0;
        default: next_st.apb.pslverr = 1'b1;
      endcase
    end

    if (wr_access && st.apb.pready) begin
      case (apb_i.paddr)
        FBG_OFF_GUARD_LOW:  next_st.guard_low  = st.guard_low | apb_i.pwdata;
        FBG_OFF_GUARD_HIGH: next_st.guard_high = st.guard_high | apb_i.pwdata[15:0];
        FBG_OFF_DBG_OVR:    next_st.dbg_ovr    = apb_i.pwdata[0];
        FBG_OFF_IRQ_STAT:   next_st.irq_clear  = apb_i.pwdata[1:0];
        FBG_OFF_IRQ_MASK:   next_st.irq_mask   = apb_i.pwdata[1:0];
        default:            next_st.irq_clear  = 2'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st            <= '0;
      st.guard_low  <= FBG_RST_GUARD_LOW;
      st.guard_high <= FBG_RST_GUARD_HIGH;
      st.dbg_ovr    <= FBG_RST_DBG_OVR;
      st.irq_mask   <= FBG_RST_IRQ_MASK;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_line;
    end
  end

  assign apb_o     = st.apb;
  assign nvm_rsp_o = st.nvm;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  guard_sticky_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (guard & $past(guard)) == $past(guard))
    else $error("guard bit cleared without reset");

  guard_reset_a: assert property (@(posedge clk_sys_i)
    $past(reset_i) |-> (st.guard_low == 32'h0 && st.guard_high == 16'h0 && st.dbg_ovr))
    else $error("reset values wrong");

  block_deny_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (nvm_req_i.valid && !st.nvm.grant && !st.nvm.deny && hit_block && !st.dbg_mode)
      |=> (st.nvm.deny && st.nvm.fault && !st.nvm.grant))
    else $error("protected block not refused");

  chip_deny_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (nvm_req_i.valid && !st.nvm.grant && !st.nvm.deny && nvm_req_i.is_erase_all
      && (|guard) && !st.dbg_mode) |=> st.nvm.deny)
    else $error("chip erase not refused");

  debug_skip_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (nvm_req_i.valid && !st.nvm.grant && !st.nvm.deny && st.dbg_mode && st.dbg_ovr)
      |=> st.nvm.grant)
    else $error("debug override not honoured");

  low_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_access && st.apb.pready && apb_i.paddr == FBG_OFF_GUARD_LOW)
      |=> ((st.guard_low & $past(apb_i.pwdata)) == $past(apb_i.pwdata)))
    else $error("low guard write lost");

  high_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_access && st.apb.pready && apb_i.paddr == FBG_OFF_GUARD_HIGH)
      |=> ((st.guard_high & $past(apb_i.pwdata[15:0])) == $past(apb_i.pwdata[15:0])))
    else $error("high guard write lost");

  spare_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_access && apb_i.paddr == FBG_OFF_SPARE) |=> (st.apb.prdata == 32'h0 && st.apb.pready))
    else $error("spare word not zero");

  override_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_access && st.apb.pready && apb_i.paddr == FBG_OFF_DBG_OVR)
      |=> (st.dbg_ovr == $past(apb_i.pwdata[0])))
    else $error("override write lost");

endmodule // fbg_guard

// >>> core/fbg_pkg.sv
// Package for the flash block write guard: offsets, layouts, reset values.
// Assumes a 32-bit APB register bus and a 20 MHz system clock.
package fbg_pkg;

  localparam int unsigned FBG_REGIONS     = 48;
  localparam int unsigned FBG_LOW_REGIONS = 32;
  localparam int unsigned FBG_BLOCK_BITS  = 12;
  localparam int unsigned FBG_ADDR_W      = 12;
  localparam int unsigned FBG_NVM_ADDR_W  = 32;

  localparam logic [11:0] FBG_OFF_GUARD_LOW  = 12'h600;
  localparam logic [11:0] FBG_OFF_GUARD_HIGH = 12'h604;
  localparam logic [11:0] FBG_OFF_DBG_OVR    = 12'h608;
  localparam logic [11:0] FBG_OFF_SPARE      = 12'h60c;
  localparam logic [11:0] FBG_OFF_IRQ_STAT   = 12'h610;
  localparam logic [11:0] FBG_OFF_IRQ_MASK   = 12'h614;

  localparam logic [31:0] FBG_RST_GUARD_LOW  = 32'h0000_0000;
  localparam logic [15:0] FBG_RST_GUARD_HIGH = 16'h0000;
  localparam logic        FBG_RST_DBG_OVR    = 1'b1;
  localparam logic [1:0]  FBG_RST_IRQ_MASK   = 2'h0;

  localparam int unsigned FBG_IRQ_BLOCK_BIT = 0;
  localparam int unsigned FBG_IRQ_CHIP_BIT  = 1;

  typedef struct packed {
    logic                      valid;
    logic                      is_erase_all;
    logic [FBG_NVM_ADDR_W-1:0] addr;
  } fbg_nvm_req_t;

  typedef struct packed {
    logic grant;
    logic deny;
    logic fault;
  } fbg_nvm_rsp_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fbg_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } fbg_apb_rsp_t;

endpackage : fbg_pkg

// >>> core/fbg_region_check.sv
// Region lookup for one memory access against the guard bits.
// Assumes byte addresses starting at the base of program memory.
module fbg_region_check
  import fbg_pkg::*;
(
  input  wire logic [FBG_REGIONS-1:0]    guard_i,
  input  wire logic [FBG_NVM_ADDR_W-1:0] addr_i,
  input  wire logic                      erase_all_i,
  output logic                           hit_block_o,
  output logic                           hit_chip_o
);
  import fbg_pkg::*;

  logic [FBG_NVM_ADDR_W-FBG_BLOCK_BITS-1:0] region;

  always_comb begin
    region      = addr_i[FBG_NVM_ADDR_W-1:FBG_BLOCK_BITS];
    hit_block_o = 1'b0;
    if (!erase_all_i && region < FBG_REGIONS) begin
      hit_block_o = guard_i[region[5:0]];
    end
    hit_chip_o = erase_all_i && (|guard_i);
  end

endmodule // fbg_region_check

// >>> core/fbg_irq.sv
// Sticky event status with mask and one level interrupt.
// Assumes events and clears come from the same clock.
module fbg_irq #(
  parameter int unsigned N = 2
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic [N-1:0] event_i,
  input  wire logic [N-1:0] clear_i,
  input  wire logic [N-1:0] mask_i,
  output logic      [N-1:0] status_o,
  output logic              irq_o
);

  typedef struct packed {
    logic [N-1:0] status;
    logic         irq;
  } fbg_irq_state_t;

  fbg_irq_state_t st;
  fbg_irq_state_t next_st;

  always_comb begin
    next_st        = st;
    next_st.status = (st.status & ~clear_i) | event_i;
    next_st.irq    = |(next_st.status & mask_i);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign status_o = st.status;
  assign irq_o    = st.irq;

endmodule // fbg_irq

// >>> tb/fbg_nvm_ctl.sv
// Flash controller model: one program or erase request at a time.
// Assumes the guard answers with grant or deny on clk_sys_i.
////////////////////////////////////////////////////////////////////////////////
module fbg_nvm_ctl
  import fbg_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire fbg_pkg::fbg_nvm_rsp_t rsp_i,
  output fbg_pkg::fbg_nvm_req_t      req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  // Holds the request until grant or deny, then shows inverted values
  task automatic access(input logic [31:0] a, input logic ea, output logic [2:0] rsp);
    int n;
    rsp = 3'h0;
    @(posedge clk_sys_i);
    req_o <= '{valid: 1'b1, is_erase_all: ea, addr: a};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys_i);
      if (rsp_i.grant | rsp_i.deny) begin
        rsp = {rsp_i.grant, rsp_i.deny, rsp_i.fault};
        break;
      end
    end
    req_o <= '{valid: 1'b0, is_erase_all: ~ea, addr: ~a};
  endtask
endmodule // fbg_nvm_ctl

// >>> tb/fbg_guard_tb.sv
// Testbench for the flash block write guard.
// Assumes the flash controller model in fbg_nvm_ctl.sv.
////////////////////////////////////////////////////////////////////////////////
module fbg_guard_tb;
  import fbg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_sys_i  = 1'b0;
  logic         reset_i    = 1'b1;
  logic         debug_mode = 1'b0;
  fbg_apb_req_t apb_req    = '0;
  fbg_apb_rsp_t apb_rsp;
  fbg_nvm_req_t nvm_req;
  fbg_nvm_rsp_t nvm_rsp;
  logic         irq;
  logic [31:0]  q;
  logic [2:0]   r;
  int           fail_count = 0;
  int           compares   = 0;
  always #25 clk_sys_i = ~clk_sys_i;

  fbg_guard fbg_guard_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .apb_i(apb_req), .apb_o(apb_rsp),
    .debug_mode_i(debug_mode), .nvm_req_i(nvm_req), .nvm_rsp_o(nvm_rsp), .irq_o(irq));
  fbg_nvm_ctl fbg_nvm_ctl_i (.clk_sys_i(clk_sys_i), .rsp_i(nvm_rsp), .req_o(nvm_req));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
    int n;
    @(posedge clk_sys_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys_i);
      if (apb_rsp.pready === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      wrap_up();
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk("read data", exp, q);
    chk("read error", {31'h0, eerr}, {31'h0, e});
  endtask

  task automatic nv(input logic [31:0] a, input logic ea, input logic [2:0] exp);
    fbg_nvm_ctl_i.access(a, ea, r);
    chk("nvm answer", {29'h0, exp}, {29'h0, r});
  endtask

  task automatic irq_is(input logic exp);
    repeat (3) @(posedge clk_sys_i);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(12'h600, 32'h0, 1'b0);
    rd(12'h604, 32'h0, 1'b0);
    rd(12'h608, 32'h1, 1'b0);
    rd(12'h60c, 32'h0, 1'b0);
    rd(12'h614, 32'h0, 1'b0);
    rd(12'h700, 32'h0, 1'b1);
    nv(32'h0, 1'b1, 3'b100);
    wr(12'h600, 32'h8000_0001);
    wr(12'h600, 32'h0);
    wr(12'h604, 32'hffff_8000);
    rd(12'h600, 32'h8000_0001, 1'b0);
    rd(12'h604, 32'h0000_8000, 1'b0);
    nv(32'h0000_0fff, 1'b0, 3'b011);
    nv(32'h0000_1000, 1'b0, 3'b100);
    nv(32'h0001_f000, 1'b0, 3'b011);
    nv(32'h0002_0000, 1'b0, 3'b100);
    nv(32'h0002_ffff, 1'b0, 3'b011);
    nv(32'h0003_0000, 1'b0, 3'b100);
    nv(32'h0, 1'b1, 3'b011);
    rd(12'h610, 32'h3, 1'b0);
    irq_is(1'b0);
    wr(12'h614, 32'h1);
    irq_is(1'b1);
    wr(12'h610, 32'h1);
    irq_is(1'b0);
    rd(12'h610, 32'h2, 1'b0);
    wr(12'h614, 32'h3);
    irq_is(1'b1);
    wr(12'h610, 32'h2);
    irq_is(1'b0);
    wr(12'h60c, 32'hffff_ffff);
    wr(12'h700, 32'hffff_ffff);
    rd(12'h600, 32'h8000_0001, 1'b0);
    rd(12'h604, 32'h0000_8000, 1'b0);
    debug_mode <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    nv(32'h0, 1'b0, 3'b100);
    nv(32'h0, 1'b1, 3'b100);
    wr(12'h608, 32'h0);
    rd(12'h608, 32'h0, 1'b0);
    nv(32'h0, 1'b0, 3'b011);
    wr(12'h608, 32'h1);
    debug_mode <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    nv(32'h0, 1'b0, 3'b011);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(12'h600, 32'h0, 1'b0);
    rd(12'h604, 32'h0, 1'b0);
    rd(12'h608, 32'h1, 1'b0);
    nv(32'h0, 1'b0, 3'b100);
    wrap_up();
  end
endmodule // fbg_guard_tb
